// ---- bench/wdh_host_model.sv ----
// Host model: classic Wishbone master that also works out refresh keys.
`timescale 1ns/100ps
`default_nettype none
module wdh_host_model (
    input  wire logic        clock_i,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic        wb_cyc_o,
    output var  logic        wb_stb_o,
    output var  logic        wb_we_o,
    output var  logic [7:0]  wb_adr_o,
    output var  logic [3:0]  wb_sel_o,
    output var  logic [31:0] wb_dat_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'hFF;
        wb_sel_o = 4'hF;
        wb_dat_o = 32'h0;
    end
    function automatic logic [7:0] next_key(input logic [7:0] k);
        next_key = {k[6:0], k[7] ^ k[5] ^ k[2] ^ k[1]};
    endfunction
    // One access; held until ack is seen, so no wait-state count is assumed.
    task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                          output logic [31:0] rdat);
        @(posedge clock_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_sel_o <= 4'hF;
        wb_adr_o <= adr;
        wb_dat_o <= wdat;
        @(posedge clock_i);
        while (wb_ack_i !== 1'b1) @(posedge clock_i);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // A released bus shows inverted values so stale data cannot pass as valid.
        wb_adr_o <= ~adr;
        wb_dat_o <= ~wdat;
    endtask
endmodule // wdh_host_model
`default_nettype wire

// ---- bench/wdh_watchdog_bench.sv ----
// Self-checking bench for the windowed host watchdog.
`timescale 1ns/100ps
`default_nettype none
`include "wdh_defs.vh"
module wdh_watchdog_bench;
    logic        clock_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        cyc, stb, we, ack, safe, chk;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rd;
    logic [7:0]  key = 8'h5A;
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;
    always #4 clock_i = ~clock_i;
    wdh_watchdog #(.BASE_CYCLES(4)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .safe_mon_o(safe), .selfcheck_o(chk));
    wdh_host_model i_host (.clock_i(clock_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.access(1'b1, a, d, rd);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        i_host.access(1'b0, a, 32'h0, rd);
        check(what, rd & m, exp);
    endtask
    task automatic wait_out(input logic want, input logic which, input int lim);
        int n;
        n = 0;
        while (((which ? chk : safe) !== want) && n < lim) begin
            @(posedge clock_i);
            n++;
        end
        check(which ? "selfcheck" : "safe mode", {31'h0, which ? chk : safe}, {31'h0, want});
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        rdc("cfg1", `WDH_ADR_CFG1, 32'hFFFFFFFF, 32'h0);
        rdc("cfg2", `WDH_ADR_CFG2, 32'hFFFFFFFF, 32'h0);
        rdc("key", `WDH_ADR_KEY, 32'hFFFFFFFF, 32'h5A);
        rdc("gdly", `WDH_ADR_GDLY, 32'hFFFFFFFF, 32'h10);
        rdc("status", `WDH_ADR_STAT, 32'hFFFFFFFF, 32'h0);
        rdc("unmapped", 8'h18, 32'hFFFFFFFF, 32'h0);
        wr(`WDH_ADR_CFG2, 32'h0101);
        // Later than a normal window, still inside the extended first one.
        repeat (100) @(posedge clock_i);
        key = i_host.next_key(key);
        wr(`WDH_ADR_KEY, {24'h0, key});
        rdc("key", `WDH_ADR_KEY, 32'hFF, {24'h0, key});
        rdc("status", `WDH_ADR_STAT, 32'hFFBF, 32'h0);
        wr(`WDH_ADR_KEY, {24'h0, ~key});
        rdc("key", `WDH_ADR_KEY, 32'hFF, {24'h0, key});
        repeat (60) @(posedge clock_i);
        rdc("status", `WDH_ADR_STAT, 32'hFFBF, 32'h0107);
        wait_out(1'b1, 1'b0, 200);
        rdc("status", `WDH_ADR_STAT, 32'hFFBF, 32'h023F);
        wait_out(1'b0, 1'b1, 100);
        check("safe mode", {31'h0, safe}, 32'h1);
        rdc("status", `WDH_ADR_STAT, 32'h80, 32'h80);
        key = i_host.next_key(key);
        wr(`WDH_ADR_KEY, {24'h0, key});
        check("safe mode", {31'h0, safe}, 32'h0);
        rdc("status", `WDH_ADR_STAT, 32'hFF00, 32'h0);
        rdc("key", `WDH_ADR_KEY, 32'hFF, {24'h0, key});
        wr(`WDH_ADR_CFG2, 32'h0001);
        rdc("status", `WDH_ADR_STAT, 32'h0F, 32'h0);
        repeat (300) @(posedge clock_i);
        check("safe mode", {31'h0, safe}, 32'h0);
        wr(`WDH_ADR_CTRL, 32'h2);
        wr(`WDH_ADR_CFG2, 32'h0100);
        repeat (300) @(posedge clock_i);
        check("safe mode", {31'h0, safe}, 32'h0);
        rdc("status", `WDH_ADR_STAT, 32'h04, 32'h0);
        // Reconfigure only with the watchdog off, to avoid undefined window states.
        wr(`WDH_ADR_CFG2, 32'h0);
        wr(`WDH_ADR_GDLY, 32'h2);
        wr(`WDH_ADR_CTRL, 32'h0);
        wr(`WDH_ADR_CFG2, 32'h0700);
        key = i_host.next_key(key);
        wr(`WDH_ADR_KEY, 32'hFFFFFFFF);
        rdc("key", `WDH_ADR_KEY, 32'hFF, {24'h0, key});
        wait_out(1'b1, 1'b0, 200);
        wait_out(1'b0, 1'b0, 40);
        rdc("status", `WDH_ADR_STAT, 32'h80, 32'h80);
        wait_out(1'b1, 1'b0, 400);
        wr(`WDH_ADR_CTRL, 32'h1);
        repeat (2) @(posedge clock_i);
        check("safe mode", {31'h0, safe}, 32'h0);
        rdc("cfg2", `WDH_ADR_CFG2, 32'hFFFFFFFF, 32'h0);
        rdc("key", `WDH_ADR_KEY, 32'hFFFFFFFF, 32'h5A);
        rdc("gdly", `WDH_ADR_GDLY, 32'hFFFFFFFF, 32'h10);
        // Divider 1, extension 1, first field 1: the first window is 72 ticks of 8 clocks.
        wr(`WDH_ADR_CFG1, 32'h0121);
        wr(`WDH_ADR_CFG2, 32'h0100);
        repeat (560) @(posedge clock_i);
        check("safe mode", {31'h0, safe}, 32'h0);
        wait_out(1'b1, 1'b0, 30);
        print_verdict();
    end
endmodule // wdh_watchdog_bench
bind wdh_watchdog wdh_watchdog_sva i_sva (.clock_i(clock_i), .reset_i(reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .safe_mon_o(safe_mon_o), .selfcheck_o(selfcheck_o));
`default_nettype wire

// ---- bench/wdh_watchdog_sva.sv ----
// Concurrent checks on the watchdog bus handshake and its mode outputs.
`timescale 1ns/100ps
`default_nettype none
module wdh_watchdog_sva (
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        safe_mon_o,
    input wire logic        selfcheck_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_ack_one_wait: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack did not follow a request after one cycle");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_safe_entry_check: assert property ($rose(safe_mon_o) |-> selfcheck_o)
        else $error("safe mode entered without self-check");
    a_check_in_safe: assert property (selfcheck_o |-> safe_mon_o)
        else $error("self-check active outside safe mode");
    a_safe_exit_cause: assert property ($fell(safe_mon_o) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i) || $past(selfcheck_o))
        else $error("safe mode left without a write or delay expiry");
    a_safe_mode_hold: assert property ((safe_mon_o && !selfcheck_o && !(wb_cyc_i && wb_stb_i)
        && !$past(wb_cyc_i && wb_stb_i)) |=> safe_mon_o)
        else $error("safe mode dropped with no cause");
endmodule // wdh_watchdog_sva
`default_nettype wire

// ---- hw/wdh_defs.vh ----
// Register map, field positions, reset values and timing constants of the watchdog.
`ifndef WDH_DEFS_VH
`define WDH_DEFS_VH

`define WDH_CLK_MHZ      125
`define WDH_BASE_US      256
`define WDH_BASE_CYCLES  (`WDH_BASE_US * `WDH_CLK_MHZ)

`define WDH_ADR_CFG1     8'h00
`define WDH_ADR_CFG2     8'h04
`define WDH_ADR_KEY      8'h08
`define WDH_ADR_STAT     8'h0C
`define WDH_ADR_CTRL     8'h10
`define WDH_ADR_GDLY     8'h14

`define WDH_CFG1_RST     16'h0000
`define WDH_CFG2_RST     11'h000
`define WDH_GDLY_RST     8'h10
`define WDH_KEY_RST      8'h5A

`define WDH_F_DIV        4:0
`define WDH_F_EXT        7:5
`define WDH_F_OPN        11:8
`define WDH_F_CLO        15:12
`define WDH_F_DBNC       6:0
`define WDH_B_EN         8
`define WDH_B_SWW        9
`define WDH_B_NO_MONITORING_BIT      10
`define WDH_B_SWRST      0
`define WDH_B_SLEEP      1

`define WDH_WIN_SHIFT    3
`define WDH_FIRST_EXTRA  16'h0002

`endif

// ---- hw/wdh_tick.v ----
// Watchdog time base: one tick every (divider + 1) base periods.
`timescale 1ns/100ps
`default_nettype none

module wdh_tick #(
    parameter BASE_CYCLES = 32000,
    parameter CW          = 16
) (
    input  wire         clock_i,
    input  wire         reset_i,
    input  wire         run_i,
    input  wire         restart_i,
    input  wire [4:0]   div_i,
    output reg          tick_o
);

    reg [CW-1:0] base_q;
    reg [4:0]    div_q;

    localparam [CW-1:0] BASE_LAST = BASE_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

    // Restarting with the window keeps every window an exact number of ticks long.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            base_q <= {CW{1'b0}};
            div_q  <= 5'h00;
            tick_o <= 1'b0;
        end else if (!run_i || restart_i) begin
            base_q <= {CW{1'b0}};
            div_q  <= 5'h00;
            tick_o <= 1'b0;
        end else if (base_q == BASE_LAST) begin
            base_q <= {CW{1'b0}};
            if (div_q >= div_i) begin
                div_q  <= 5'h00;
                tick_o <= 1'b1;
            end else begin
                div_q  <= div_q + 5'h01;
                tick_o <= 1'b0;
            end
        end else begin
            base_q <= base_q + {{(CW-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end

endmodule // wdh_tick

`default_nettype wire

// ---- hw/wdh_watchdog.v ----
// Windowed host watchdog with fault debounce, safe monitoring entry and self-check.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "wdh_defs.vh"

module wdh_watchdog #(
    parameter BASE_CYCLES = `WDH_BASE_CYCLES
) (
    input  wire         clock_i,
    input  wire         reset_i,
    input  wire         wb_cyc_i,
    input  wire         wb_stb_i,
    input  wire         wb_we_i,
    input  wire [7:0]   wb_adr_i,
    input  wire [3:0]   wb_sel_i,
    input  wire [31:0]  wb_dat_i,
    output reg  [31:0]  wb_dat_o,
    output reg          wb_ack_o,
    output wire         safe_mon_o,
    output wire         selfcheck_o
);

    // One step of the key sequence.
    function [7:0] wdh_lfsr;
        input [7:0] k;
        begin
            wdh_lfsr = {k[6:0], k[7] ^ k[5] ^ k[2] ^ k[1]};
        end
    endfunction

    // Length in ticks of one window part: the field plus one, times eight.
    function [15:0] wdh_span;
        input [3:0] field;
        begin
            wdh_span = ({12'h000, field} + 16'h0001) << `WDH_WIN_SHIFT;
        end
    endfunction

    function wdh_hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            wdh_hit = (adr[7:2] == off[7:2]);
        end
    endfunction

    // Byte-lane merge of a write into an existing register value.
    function [31:0] wdh_merge;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0]  sel;
        reg   [31:0] m;
        begin
            m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
            wdh_merge = (old & ~m) | (wdat & m);
        end
    endfunction

    reg [15:0] cfg1_q;
    reg [10:0] cfg2_q;
    reg [7:0]  gdly_q;
    reg        sleep_q;
    reg        swr_q;
    reg [7:0]  key_q;
    reg [15:0] win_q;
    reg        first_q;
    reg [7:0]  fault_q;
    reg        mism_q;
    reg        rjct_q;
    reg        expy_q;
    reg        toer_q;
    reg        safe_q;
    reg        schk_q;
    reg        schk_to_q;
    reg [7:0]  dly_q;
    reg [31:0] rdata;

    wire        tick;
    wire        acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wr      = acc && wb_we_i;
    wire        wr_cfg1 = wr && wdh_hit(wb_adr_i, `WDH_ADR_CFG1);
    wire        wr_cfg2 = wr && wdh_hit(wb_adr_i, `WDH_ADR_CFG2);
    wire        wr_ctrl = wr && wdh_hit(wb_adr_i, `WDH_ADR_CTRL);
    wire        wr_gdly = wr && wdh_hit(wb_adr_i, `WDH_ADR_GDLY);
    // Only the low byte of a key write is decoded; the upper lanes are ignored.
    wire        kw      = wr && wdh_hit(wb_adr_i, `WDH_ADR_KEY) && wb_sel_i[0];

    wire        en      = cfg2_q[`WDH_B_EN];
    wire        sww     = cfg2_q[`WDH_B_SWW];
    wire        no_monitoring_bit   = cfg2_q[`WDH_B_NO_MONITORING_BIT];
    // Sleep and a cleared enable both stop the window, the time base and the debounce.
    wire        wd_run  = en && !sleep_q;

    wire [31:0] cfg1_new = wdh_merge({16'h0000, cfg1_q}, wb_dat_i, wb_sel_i);
    wire [31:0] cfg2_new = wdh_merge({21'h0, cfg2_q}, wb_dat_i, wb_sel_i);
    wire        clr_err  = wr_cfg2 && !cfg2_new[`WDH_B_EN];

    wire [15:0] t1     = wdh_span(cfg1_q[`WDH_F_OPN]);
    wire [15:0] t_open = wdh_span(cfg1_q[`WDH_F_CLO]);
    wire [15:0] t2     = t1 + t_open;
    wire [15:0] ext2   = {13'h0000, cfg1_q[`WDH_F_EXT]} + `WDH_FIRST_EXTRA;
    wire [31:0] tfirst = t2 * ext2;
    // The first window after enable or a return from safe monitoring is open
    // throughout, so a slow host start-up cannot trip the early-write error.
    wire [15:0] win_end = first_q ? tfirst[15:0] : t2;
    wire        closed  = !first_q && (win_q < t1);
    // The debounce field stores the limit minus one so that 128 fits in seven bits.
    wire [7:0]  limit   = {1'b0, cfg2_q[`WDH_F_DBNC]} + 8'h01;
    wire [7:0]  fault_n = fault_q + 8'h01;

    wire        key_ok  = sww || (wb_dat_i[7:0] == wdh_lfsr(key_q));
    // Safe monitoring freezes the window counter until the mode is left.
    wire        normal  = wd_run && !safe_q;
    wire        open_now = !closed && normal;
    wire        refresh = normal && kw && !closed && key_ok;
    wire        ret_ev  = wd_run && safe_q && kw && key_ok;
    // A key write that meets the final tick defers the timeout by one tick
    // rather than racing it, so a valid refresh always wins over expiry.
    wire        to_ev   = normal && !kw && tick && (win_q + 16'h0001 >= win_end);
    wire        trip    = to_ev && (fault_n >= limit);
    wire        dly_end = wd_run && safe_q && !ret_ev && schk_q && tick && (dly_q >= gdly_q);
    wire        nm_ret  = dly_end && no_monitoring_bit;
    wire        restart = !wd_run || refresh || ret_ev || to_ev || nm_ret;

    // Restarting the time base with each window trades tick phase for exact window lengths.
    wdh_tick #(
        .BASE_CYCLES (BASE_CYCLES),
        .CW          (16)
    ) u_tick (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .run_i     (wd_run),
        .restart_i (restart),
        .div_i     (cfg1_q[`WDH_F_DIV]),
        .tick_o    (tick)
    );

    // Wishbone classic: one wait state, every access acknowledged.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= (acc && !wb_we_i) ? rdata : 32'h00000000;
        end
    end

    always @* begin
        rdata = 32'h00000000;
        if (wdh_hit(wb_adr_i, `WDH_ADR_CFG1)) begin
            rdata = {16'h0000, cfg1_q};
        end else if (wdh_hit(wb_adr_i, `WDH_ADR_CFG2)) begin
            rdata = {21'h000000, cfg2_q};
        end else if (wdh_hit(wb_adr_i, `WDH_ADR_KEY)) begin
            rdata = {24'h000000, key_q};
        end else if (wdh_hit(wb_adr_i, `WDH_ADR_STAT)) begin
            // Bit 6 tells the host whether a refresh would be accepted right now.
            rdata = {16'h0000, fault_q, schk_to_q, open_now,
                     schk_q, safe_q, toer_q, expy_q, rjct_q, mism_q};
        end else if (wdh_hit(wb_adr_i, `WDH_ADR_CTRL)) begin
            rdata = {30'h00000000, sleep_q, 1'b0};
        end else if (wdh_hit(wb_adr_i, `WDH_ADR_GDLY)) begin
            rdata = {24'h000000, gdly_q};
        end
    end

    // Software reset is taken one cycle after its write so the acknowledging
    // bus cycle completes cleanly before every register returns to default.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            swr_q <= 1'b0;
        end else begin
            swr_q <= wr_ctrl && wb_sel_i[0] && wb_dat_i[`WDH_B_SWRST];
        end
    end

    // Configuration registers.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cfg1_q  <= `WDH_CFG1_RST;
            cfg2_q  <= `WDH_CFG2_RST;
            gdly_q  <= `WDH_GDLY_RST;
            sleep_q <= 1'b0;
        end else if (swr_q) begin
            cfg1_q  <= `WDH_CFG1_RST;
            cfg2_q  <= `WDH_CFG2_RST;
            gdly_q  <= `WDH_GDLY_RST;
            sleep_q <= 1'b0;
        end else begin
            if (wr_cfg1) begin
                cfg1_q <= cfg1_new[15:0];
            end
            if (wr_cfg2) begin
                cfg2_q <= cfg2_new[10:0];
            end
            if (wr_gdly && wb_sel_i[0]) begin
                gdly_q <= wb_dat_i[7:0];
            end
            if (wr_ctrl && wb_sel_i[0]) begin
                sleep_q <= wb_dat_i[`WDH_B_SLEEP];
            end
        end
    end

    // Window timing, key and fault counting.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            key_q   <= `WDH_KEY_RST;
            win_q   <= 16'h0000;
            first_q <= 1'b1;
            fault_q <= 8'h00;
        end else if (swr_q) begin
            key_q   <= `WDH_KEY_RST;
            win_q   <= 16'h0000;
            first_q <= 1'b1;
            fault_q <= 8'h00;
        end else begin
            if (!wd_run) begin
                win_q   <= 16'h0000;
                first_q <= 1'b1;
            end else if (refresh || ret_ev) begin
                win_q   <= 16'h0000;
                first_q <= ret_ev;
                key_q   <= wdh_lfsr(key_q);
            end else if (nm_ret) begin
                win_q   <= 16'h0000;
                first_q <= 1'b1;
            end else if (to_ev) begin
                win_q   <= 16'h0000;
                first_q <= 1'b0;
            end else if (normal && tick) begin
                win_q <= win_q + 16'h0001;
            end
            // Clearing on a write that clears the enable bit lets a re-enabled watchdog start its
            // debounce from zero instead of inheriting faults of an old session.
            if (refresh || ret_ev || clr_err) begin
                fault_q <= 8'h00;
            end else if (to_ev) begin
                fault_q <= fault_n;
            end
        end
    end

    // Error flags: the clear from a write that clears the enable bit loses to a same-cycle event.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mism_q <= 1'b0;
            rjct_q <= 1'b0;
            expy_q <= 1'b0;
            toer_q <= 1'b0;
        end else if (swr_q) begin
            mism_q <= 1'b0;
            rjct_q <= 1'b0;
            expy_q <= 1'b0;
            toer_q <= 1'b0;
        end else begin
            if (normal && kw && !sww && !key_ok) begin
                mism_q <= 1'b1;
            end else if (clr_err) begin
                mism_q <= 1'b0;
            end
            if (normal && kw && !sww && closed) begin
                rjct_q <= 1'b1;
            end else if (clr_err) begin
                rjct_q <= 1'b0;
            end
            if (to_ev) begin
                expy_q <= 1'b1;
            end else if (clr_err) begin
                expy_q <= 1'b0;
            end
            if (trip) begin
                toer_q <= 1'b1;
            end else if (clr_err) begin
                toer_q <= 1'b0;
            end
        end
    end

    // Safe monitoring mode and the watchdog self-check that starts with it.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            safe_q    <= 1'b0;
            schk_q    <= 1'b0;
            schk_to_q <= 1'b0;
            dly_q     <= 8'h00;
        end else if (swr_q) begin
            safe_q    <= 1'b0;
            schk_q    <= 1'b0;
            schk_to_q <= 1'b0;
            dly_q     <= 8'h00;
        end else if (trip) begin
            safe_q    <= 1'b1;
            schk_q    <= 1'b1;
            schk_to_q <= 1'b0;
            dly_q     <= 8'h00;
        end else if (ret_ev) begin
            safe_q <= 1'b0;
            schk_q <= 1'b0;
        end else if (dly_end) begin
            schk_q    <= 1'b0;
            schk_to_q <= 1'b1;
            if (no_monitoring_bit) begin
                safe_q <= 1'b0;
            end
        end else if (wd_run && safe_q && schk_q && tick) begin
            // The recovery delay counts watchdog ticks, so it scales with the divider.
            dly_q <= dly_q + 8'h01;
        end
    end

    assign safe_mon_o  = safe_q;
    assign selfcheck_o = schk_q;

endmodule // wdh_watchdog

`default_nettype wire
